// ### src/ncc_commit_ctrl.sv
/*
 * Commit, checksum and step control behind register 3h: moves configuration between the
 * two-page nonvolatile array and the live registers, runs or skips the checksum, and issues
 * divider step commands with per-channel include masks.
 * Assumes a serial port engine on core_clk giving word accesses, an array engine on core_clk
 * answering each start with a one-cycle done, and asynchronous pins and clock status.
 */
`timescale 1ns/10ps
module ncc_commit_ctrl (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    // Word access from the serial port engine
    input  wire logic [7:0]             regAddr,
    input  wire logic                   regWrEn,
    input  wire logic [15:0]            regWrData,
    input  wire logic                   regRdEn,
    output logic [15:0]                 regRdData,
    output logic                        regRdAck,
    output logic                        regRdRefused,
    // Reset causes and straps
    input  wire logic                   softResetReq,
    input  wire logic                   pinResetReq,
    input  wire logic                   page_select_pin,
    input  wire logic                   pageSelectEnable,
    // Always-on clock control
    input  wire logic                   aonClkRunning,
    input  wire logic                   pllLocked,
    input  wire logic                   keep_always_on_after_lock,
    input  wire logic                   clock_debug_register_aon_force,
    output logic                        aonClkEnable,
    // Nonvolatile array engine
    output ncc_pkg::ncc_nvm_cmd_t       nvmCmd,
    output logic                        nvmStart,
    input  wire logic                   nvmDone,
    output logic                        nvmBusy,
    // Divider stepping
    input  wire logic                   frequency_step_up_input,
    input  wire logic                   frequency_step_down_input,
    output ncc_pkg::ncc_step_cmd_t      stepCmd
);
    logic [15:0]         ctrl_q;
    ncc_pkg::ncc_state_t state_q;
    ncc_pkg::ncc_op_t    op_q;
    logic                opPage_q;
    logic                opCrc_q;
    logic                bootPend_q;
    logic                bootDone_q;
    logic                resetPend_q;
    logic [1:0]          pageSync_q;
    logic [1:0]          pageEnSync_q;
    logic [1:0]          aonSync_q;
    logic                stepUpReq_q;
    logic                stepDownReq_q;
    logic                stepUp;
    logic                stepDown;
    logic                wrHit;
    logic                rdHit;
    logic                idleTake;
    logic                loadTake;
    logic                opDone;

    assign wrHit    = regWrEn && (regAddr == ncc_pkg::REG_COMMIT_STEP_OFFS);
    assign rdHit    = regRdEn && (regAddr == ncc_pkg::REG_COMMIT_STEP_OFFS);
    assign opDone   = (state_q == ncc_pkg::NCC_RUN) && nvmDone;
    // A request is taken only from idle; a reset reload beats software requests
    assign idleTake = (state_q == ncc_pkg::NCC_IDLE) && (bootPend_q || resetPend_q
                      || ctrl_q[ncc_pkg::LOAD_NVM_BIT] || ctrl_q[ncc_pkg::STORE_NVM_BIT]
                      || ctrl_q[ncc_pkg::RECOMPUTE_CRC_BIT]);
    assign loadTake = idleTake && (bootPend_q || resetPend_q || ctrl_q[ncc_pkg::LOAD_NVM_BIT]);

    // Pin and clock status synchronisers
    // No reset on purpose: they keep sampling through srst, so the power-on load taken at
    // the first edge after release already sees the page strap and its enable. A reset
    // here would hand that load page 0 whatever the pin says.
    always_ff @(posedge core_clk) begin
        pageSync_q   <= {pageSync_q[0], page_select_pin};
        pageEnSync_q <= {pageEnSync_q[0], pageSelectEnable};
        aonSync_q    <= {aonSync_q[0], aonClkRunning};
    end

    // Reload requests: power-on boot once after srst, soft or pin reset at any time
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bootPend_q  <= 1'b1;
            bootDone_q  <= 1'b0;
            resetPend_q <= 1'b0;
        end else begin
            if (idleTake && bootPend_q) begin
                bootPend_q <= 1'b0;
            end
            if (opDone && !bootDone_q) begin
                bootDone_q <= 1'b1;
            end
            // Set wins over the take in the same cycle
            if (softResetReq || pinResetReq) begin
                resetPend_q <= 1'b1;
            end else if (idleTake && !bootPend_q) begin
                resetPend_q <= 1'b0;
            end
        end
    end

    // Control register: software sets, hardware clears; a set in the clear cycle survives
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_q <= ncc_pkg::REG_COMMIT_STEP_RST;
        end else begin
            if (loadTake && !bootPend_q && !resetPend_q) begin
                ctrl_q[ncc_pkg::LOAD_NVM_BIT] <= 1'b0;
            end
            if (opDone && op_q == ncc_pkg::NCC_OP_STORE) begin
                ctrl_q[ncc_pkg::STORE_NVM_BIT] <= 1'b0;
            end
            if (opDone && op_q == ncc_pkg::NCC_OP_CRC) begin
                ctrl_q[ncc_pkg::RECOMPUTE_CRC_BIT] <= 1'b0;
            end
            ctrl_q[ncc_pkg::STEP_UP_BIT]   <= 1'b0;
            ctrl_q[ncc_pkg::STEP_DOWN_BIT] <= 1'b0;
            if (wrHit) begin
                ctrl_q[ncc_pkg::SKIP_CRC_BIT]                        <= regWrData[15];
                ctrl_q[ncc_pkg::STORE_PAGE_BIT:ncc_pkg::STEP_SOURCE_BIT] <= regWrData[11:0];
                // Start bits only ever set from a write
                if (regWrData[ncc_pkg::RECOMPUTE_CRC_BIT]) begin
                    ctrl_q[ncc_pkg::RECOMPUTE_CRC_BIT] <= 1'b1;
                end
                if (regWrData[ncc_pkg::LOAD_NVM_BIT]) begin
                    ctrl_q[ncc_pkg::LOAD_NVM_BIT] <= 1'b1;
                end
                if (regWrData[ncc_pkg::STORE_NVM_BIT]) begin
                    ctrl_q[ncc_pkg::STORE_NVM_BIT] <= 1'b1;
                end
            end
        end
    end

    // Operation sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q  <= ncc_pkg::NCC_IDLE;
            op_q     <= ncc_pkg::NCC_OP_LOAD;
            opPage_q <= 1'b0;
            opCrc_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ncc_pkg::NCC_IDLE: begin
                    if (idleTake) begin
                        state_q <= ncc_pkg::NCC_WAIT_CLK;
                        if (bootPend_q) begin
                            op_q     <= ncc_pkg::NCC_OP_LOAD;
                            opPage_q <= pageSync_q[1];
                            opCrc_q  <= pageEnSync_q[1] | ~ctrl_q[ncc_pkg::SKIP_CRC_BIT];
                        end else if (resetPend_q || ctrl_q[ncc_pkg::LOAD_NVM_BIT]) begin
                            op_q     <= ncc_pkg::NCC_OP_LOAD;
                            opPage_q <= ctrl_q[ncc_pkg::STORE_PAGE_BIT];
                            opCrc_q  <= ~ctrl_q[ncc_pkg::SKIP_CRC_BIT];
                        end else if (ctrl_q[ncc_pkg::STORE_NVM_BIT]) begin
                            op_q     <= ncc_pkg::NCC_OP_STORE;
                            opPage_q <= ctrl_q[ncc_pkg::STORE_PAGE_BIT];
                            opCrc_q  <= 1'b0;
                        end else begin
                            op_q     <= ncc_pkg::NCC_OP_CRC;
                            opPage_q <= ctrl_q[ncc_pkg::STORE_PAGE_BIT];
                            opCrc_q  <= 1'b1;
                        end
                    end
                end
                ncc_pkg::NCC_WAIT_CLK: begin
                    // Array access needs the always-on clock; every operation holds here until it runs
                    if (aonSync_q[1]) begin
                        state_q <= ncc_pkg::NCC_RUN;
                    end
                end
                ncc_pkg::NCC_RUN: begin
                    if (nvmDone) begin
                        state_q <= ncc_pkg::NCC_IDLE;
                    end
                end
            endcase
        end
    end

    assign nvmStart = (state_q == ncc_pkg::NCC_WAIT_CLK) && aonSync_q[1];
    assign nvmCmd   = '{op: op_q, page: opPage_q, withCrc: opCrc_q};
    assign nvmBusy  = (state_q != ncc_pkg::NCC_IDLE);
    // Clock stays on while unlocked, while busy, or when kept or forced
    assign aonClkEnable = ~pllLocked | nvmBusy | keep_always_on_after_lock
                          | clock_debug_register_aon_force;

    // Read port: one-cycle answer; refused with zero data while a load runs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            regRdData    <= 16'h0000;
            regRdAck     <= 1'b0;
            regRdRefused <= 1'b0;
        end else begin
            regRdAck     <= regRdEn;
            regRdRefused <= regRdEn && nvmBusy && (op_q == ncc_pkg::NCC_OP_LOAD);
            if (regRdEn && nvmBusy && (op_q == ncc_pkg::NCC_OP_LOAD)) begin
                regRdData <= 16'h0000;
            end else if (rdHit) begin
                regRdData <= ctrl_q;
            end else begin
                regRdData <= 16'h0000;
            end
        end
    end

    // Register step requests, one cycle wide, taken from the written word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stepUpReq_q   <= 1'b0;
            stepDownReq_q <= 1'b0;
        end else begin
            stepUpReq_q   <= wrHit && regWrData[ncc_pkg::STEP_UP_BIT];
            stepDownReq_q <= wrHit && regWrData[ncc_pkg::STEP_DOWN_BIT];
        end
    end

    ncc_step_source upSource (
        .core_clk    (core_clk),
        .srst        (srst),
        .stepPin     (frequency_step_up_input),
        .regRequest  (stepUpReq_q),
        .useRegister (ctrl_q[ncc_pkg::STEP_SOURCE_BIT]),
        .stepPulse   (stepUp)
    );

    ncc_step_source downSource (
        .core_clk    (core_clk),
        .srst        (srst),
        .stepPin     (frequency_step_down_input),
        .regRequest  (stepDownReq_q),
        .useRegister (ctrl_q[ncc_pkg::STEP_SOURCE_BIT]),
        .stepPulse   (stepDown)
    );

    // Include masks travel with the pulse; the datapath steps only included dividers
    assign stepCmd = '{up: stepUp, down: stepDown,
                       intInclude: ctrl_q[ncc_pkg::INT_MASK_HI:ncc_pkg::INT_MASK_LO],
                       fracInclude: ctrl_q[ncc_pkg::FRAC_MASK_HI:ncc_pkg::FRAC_MASK_LO]};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    boot_load_a: assert property ($fell(srst) |-> ##[1:3] (state_q == ncc_pkg::NCC_WAIT_CLK
        && op_q == ncc_pkg::NCC_OP_LOAD)) else $error("No load after reset");
    boot_crc_a: assert property (nvmStart && !bootDone_q && pageEnSync_q[1]
        |-> nvmCmd.withCrc) else $error("Power-on load skipped checksum");
    skip_crc_a: assert property (idleTake && !bootPend_q && resetPend_q
        && ctrl_q[ncc_pkg::SKIP_CRC_BIT] |=> !opCrc_q) else $error("Reload kept checksum");
    load_clear_a: assert property (loadTake && !bootPend_q && !resetPend_q
        && !(wrHit && regWrData[ncc_pkg::LOAD_NVM_BIT]) |=> !ctrl_q[ncc_pkg::LOAD_NVM_BIT])
        else $error("Load bit not cleared");
    store_hold_a: assert property (state_q == ncc_pkg::NCC_RUN && op_q == ncc_pkg::NCC_OP_STORE
        && !nvmDone |=> ctrl_q[ncc_pkg::STORE_NVM_BIT]) else $error("Store bit cleared early");
    crc_clear_a: assert property (opDone && op_q == ncc_pkg::NCC_OP_CRC && !wrHit
        |=> !ctrl_q[ncc_pkg::RECOMPUTE_CRC_BIT] && !nvmBusy) else $error("Recompute bit stuck");
    clk_wait_a: assert property (
        state_q == ncc_pkg::NCC_WAIT_CLK && !aonSync_q[1]
        |-> !nvmStart ##1 (state_q == ncc_pkg::NCC_WAIT_CLK))
        else $error("Start without always-on clock");
    read_block_a: assert property (regRdEn && nvmBusy && op_q == ncc_pkg::NCC_OP_LOAD
        |=> regRdRefused && regRdData == 16'h0000) else $error("Read served during load");
    aon_keep_a: assert property (keep_always_on_after_lock || clock_debug_register_aon_force
        |-> aonClkEnable) else $error("Always-on clock dropped");
    busy_span_a: assert property (
        nvmStart || (state_q == ncc_pkg::NCC_RUN && !nvmDone) |=> nvmBusy)
        else $error("Busy fell during operation");
    busy_end_a: assert property (
        opDone || (state_q == ncc_pkg::NCC_IDLE && !idleTake) |=> !nvmBusy)
        else $error("Busy high while idle");
    step_reg_a: assert property (wrHit && regWrData[ncc_pkg::STEP_UP_BIT]
        && regWrData[ncc_pkg::STEP_SOURCE_BIT] |-> ##2 stepCmd.up) else $error("Register step lost");
    boot_page_a: assert property (
        idleTake && bootPend_q |=> opPage_q == $past(pageSync_q[1]))
        else $error("Power-on load ignored page pin");
    store_take_a: assert property (
        idleTake && !bootPend_q && !resetPend_q && !ctrl_q[ncc_pkg::LOAD_NVM_BIT]
        && ctrl_q[ncc_pkg::STORE_NVM_BIT] |=> op_q == ncc_pkg::NCC_OP_STORE && nvmBusy)
        else $error("Store not started");
    page_sel_a: assert property (idleTake && !bootPend_q
        |=> opPage_q == $past(ctrl_q[ncc_pkg::STORE_PAGE_BIT])) else $error("Wrong page");

    load_run_c: cover property (nvmStart && op_q == ncc_pkg::NCC_OP_LOAD && bootDone_q);
    store_run_c: cover property (opDone && op_q == ncc_pkg::NCC_OP_STORE);
    crc_run_c: cover property (opDone && op_q == ncc_pkg::NCC_OP_CRC);
    reset_load_c: cover property (idleTake && resetPend_q && !bootPend_q);
    pin_step_c: cover property (stepCmd.down && !ctrl_q[ncc_pkg::STEP_SOURCE_BIT]);
endmodule

// ### src/ncc_pkg.sv
/*
 * Package of the commit, checksum and step control block: register offset, field positions,
 * reset value, operation codes, state enumeration and the packed carriers.
 * Assumes a 50 MHz core clock and a 16-bit register word from the serial port engine.
 */
package ncc_pkg;

    localparam logic [7:0]  REG_COMMIT_STEP_OFFS = 8'h03;
    localparam logic [15:0] REG_COMMIT_STEP_RST  = 16'h0000;

    // Field positions inside nonvolatile_commit_and_step_control
    localparam int SKIP_CRC_BIT      = 15;
    localparam int RECOMPUTE_CRC_BIT = 14;
    localparam int LOAD_NVM_BIT      = 13;
    localparam int STORE_NVM_BIT     = 12;
    localparam int STORE_PAGE_BIT    = 11;
    localparam int INT_MASK_HI       = 10;
    localparam int INT_MASK_LO       = 7;
    localparam int FRAC_MASK_HI      = 6;
    localparam int FRAC_MASK_LO      = 3;
    localparam int STEP_DOWN_BIT     = 2;
    localparam int STEP_UP_BIT       = 1;
    localparam int STEP_SOURCE_BIT   = 0;

    // Synchroniser depth for the step pin inputs
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        NCC_OP_LOAD  = 2'h0,
        NCC_OP_STORE = 2'h1,
        NCC_OP_CRC   = 2'h2
    } ncc_op_t;

    typedef enum logic [1:0] {
        NCC_IDLE,
        NCC_WAIT_CLK,
        NCC_RUN
    } ncc_state_t;

    // Command towards the nonvolatile array engine
    typedef struct packed {
        ncc_op_t    op;
        logic       page;
        logic       withCrc;
    } ncc_nvm_cmd_t;

    // Step command towards the divider stepping datapath
    typedef struct packed {
        logic       up;
        logic       down;
        logic [3:0] intInclude;
        logic [3:0] fracInclude;
    } ncc_step_cmd_t;

endpackage

// ### src/ncc_step_source.sv
/*
 * One step direction: synchronises the pin input, finds its rising edge and chooses between
 * the pin edge and the register request.
 * Assumes the pin is asynchronous to core_clk and the register request is a one-cycle pulse.
 */
`timescale 1ns/10ps
module ncc_step_source (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic stepPin,
    input  wire logic regRequest,
    input  wire logic useRegister,
    output logic      stepPulse
);
    logic [ncc_pkg::SYNC_STAGES-1:0] sync_q;
    logic                            last_q;

    // Two flip-flops before anyone looks at the pin
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_q <= '0;
            last_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[ncc_pkg::SYNC_STAGES-2:0], stepPin};
            last_q <= sync_q[ncc_pkg::SYNC_STAGES-1];
        end
    end

    // Source select; edge is taken only from the second stage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stepPulse <= 1'b0;
        end else if (useRegister) begin
            stepPulse <= regRequest;
        end else begin
            stepPulse <= sync_q[ncc_pkg::SYNC_STAGES-1] & ~last_q;
        end
    end
endmodule

// ### tb/ncc_nvm_engine_model.sv
/*
 * Behavioural model of the nonvolatile array engine: takes each start, records the command
 * and answers with a one-cycle done after a chosen number of extra cycles.
 * Assumes starts arrive on core_clk, one operation at a time.
 */
`timescale 1ns/10ps
module ncc_nvm_engine_model (
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    input  wire logic                  nvmStart,
    input  wire ncc_pkg::ncc_nvm_cmd_t nvmCmd,
    input  wire logic [7:0]            lateCycles,
    output logic                       nvmDone,
    output ncc_pkg::ncc_nvm_cmd_t      lastCmd,
    output int                         startCount
);
    initial begin
        nvmDone = 1'b0;
        lastCmd = '0;
        startCount = 0;
    end

    // Blocks while busy, so a second start in mid-operation would be missed on purpose
    always @(posedge core_clk) begin
        if (srst === 1'b0 && nvmStart === 1'b1) begin
            lastCmd = nvmCmd;
            startCount = startCount + 1;
            repeat (lateCycles) @(posedge core_clk);
            #1 nvmDone = 1'b1;
            @(posedge core_clk);
            #1 nvmDone = 1'b0;
        end
    end
endmodule

// ### tb/test_ncc_commit_ctrl.sv
/*
 * Self-checking bench of the commit, checksum and step control block.
 * Assumes the engine model in its own file; inputs change 1 ns after the rising edge.
 */
`timescale 1ns/10ps
module test_ncc_commit_ctrl;
    logic core_clk = 1'b0, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h03, lateCycles = 8'h00;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic regRdAck, regRdRefused, softResetReq = 1'b0, pinResetReq = 1'b0;
    logic pagePin = 1'b1, pageEn = 1'b1, aonRun = 1'b1, pllLocked = 1'b0;
    logic keepAon = 1'b0, forceAon = 1'b0, aonClkEnable, nvmStart, nvmDone, nvmBusy;
    logic upPin = 1'b0, downPin = 1'b0;
    ncc_pkg::ncc_nvm_cmd_t nvmCmd, lastCmd;
    ncc_pkg::ncc_step_cmd_t stepCmd;
    int startCount, mismatches = 0, checks = 0, upCount = 0, downCount = 0;
    logic [15:0] rdv;
    logic rf;

    always #10 core_clk = ~core_clk;

    ncc_commit_ctrl dut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdAck(regRdAck), .regRdRefused(regRdRefused), .softResetReq(softResetReq),
        .pinResetReq(pinResetReq), .page_select_pin(pagePin), .pageSelectEnable(pageEn),
        .aonClkRunning(aonRun), .pllLocked(pllLocked), .keep_always_on_after_lock(keepAon),
        .clock_debug_register_aon_force(forceAon), .aonClkEnable(aonClkEnable),
        .nvmCmd(nvmCmd), .nvmStart(nvmStart), .nvmDone(nvmDone), .nvmBusy(nvmBusy),
        .frequency_step_up_input(upPin), .frequency_step_down_input(downPin),
        .stepCmd(stepCmd));

    ncc_nvm_engine_model engine (.core_clk(core_clk), .srst(srst), .nvmStart(nvmStart),
        .nvmCmd(nvmCmd), .lateCycles(lateCycles), .nvmDone(nvmDone), .lastCmd(lastCmd),
        .startCount(startCount));

    // Step pulses are counted here so that pin-driven steps need no exact latency
    always @(posedge core_clk) begin
        if (stepCmd.up === 1'b1) upCount++;
        if (stepCmd.down === 1'b1) downCount++;
    end

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick;
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic r);
        regAddr = a;
        regRdEn = 1'b1;
        tick;
        regRdEn = 1'b0;
        chk("read ack", 16'h0001, {15'h0, regRdAck});
        d = regRdData;
        r = regRdRefused;
    endtask

    // Bounded wait for busy to fall, then the command seen by the engine is judged
    task automatic op_done(input logic [3:0] exp, input logic [3:0] care);
        int i;
        for (i = 0; i < 200; i++) begin
            tick;
            if (nvmBusy === 1'b0) break;
        end
        chk("busy falls", 16'h0000, {15'h0, nvmBusy});
        chk("engine command", {12'h0, exp & care}, {12'h0, lastCmd & care});
    endtask

    task automatic test_boot;
        tick;
        chk("boot busy", 16'h0001, {15'h0, nvmBusy});
        rd(8'h03, rdv, rf);
        chk("boot read refused", 16'h0001, {15'h0, rf});
        chk("boot read data", 16'h0000, rdv);
        op_done({ncc_pkg::NCC_OP_LOAD, 1'b1, 1'b1}, 4'hF);
        rd(8'h03, rdv, rf);
        chk("reset value", 16'h0000, rdv);
        tick;
        rd(8'h04, rdv, rf);
        chk("unmapped read", 16'h0000, rdv);
    endtask

    task automatic test_aon;
        int i;
        pllLocked = 1'b1;
        for (i = 0; i < 4; i++) begin
            {keepAon, forceAon} = i[1:0];
            tick;
            chk("aon enable", {15'h0, i != 0}, {15'h0, aonClkEnable});
        end
        {pllLocked, keepAon, forceAon} = 3'b000;
    endtask

    task automatic test_load;
        int s;
        aonRun = 1'b0;
        lateCycles = 8'h03;
        s = startCount;
        wr(8'h03, 16'h2800);
        tick;
        chk("load busy", 16'h0001, {15'h0, nvmBusy});
        repeat (6) tick;
        chk("no start without clock", s[15:0], startCount[15:0]);
        rd(8'h03, rdv, rf);
        chk("load read refused", 16'h0001, {15'h0, rf});
        aonRun = 1'b1;
        op_done({ncc_pkg::NCC_OP_LOAD, 1'b1, 1'b1}, 4'hF);
        rd(8'h03, rdv, rf);
        chk("load bit cleared", 16'h0800, rdv);
    endtask

    // Store and recompute share one flow: the start bit stays up until done
    task automatic test_store_crc(input logic [15:0] d, input ncc_pkg::ncc_op_t op);
        lateCycles = 8'h04;
        wr(8'h03, d);
        tick;
        rd(8'h03, rdv, rf);
        chk("bit held while running", d, rdv);
        chk("store read served", 16'h0000, {15'h0, rf});
        op_done({op, 1'b0, op == ncc_pkg::NCC_OP_CRC},
                {2'b11, op == ncc_pkg::NCC_OP_STORE, 1'b1});
        rd(8'h03, rdv, rf);
        chk("bit cleared at done", 16'h0000, rdv);
    endtask

    task automatic test_resets;
        int i;
        lateCycles = 8'h01;
        for (i = 0; i < 3; i++) begin
            wr(8'h03, (i < 2) ? 16'h8000 : 16'h0000);
            tick;
            if (i == 1) pinResetReq = 1'b1;
            else softResetReq = 1'b1;
            tick;
            {pinResetReq, softResetReq} = 2'b00;
            op_done({ncc_pkg::NCC_OP_LOAD, 1'b0, i == 2}, 4'hF);
        end
        rd(8'h03, rdv, rf);
        chk("reg kept over reload", 16'h0000, rdv);
    endtask

    task automatic test_step;
        int u;
        wr(8'h03, 16'h052B);
        tick;
        chk("step up", 16'h02A5, {6'h0, stepCmd});
        tick;
        chk("step up ends", 16'h00A5, {6'h0, stepCmd});
        wr(8'h03, 16'h052D);
        tick;
        chk("step down", 16'h01A5, {6'h0, stepCmd});
        u = upCount;
        upPin = 1'b1;
        repeat (8) tick;
        chk("pin ignored in register mode", u[15:0], upCount[15:0]);
        upPin = 1'b0;
        wr(8'h03, 16'h0528);
        u = downCount;
        downPin = 1'b1;
        repeat (8) tick;
        chk("pin step down", u[15:0] + 16'h0001, downCount[15:0]);
        downPin = 1'b0;
        tick;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Whole run needs well under 1000 cycles; this limit only cuts a hang short
    initial begin
        #100us;
        mismatches++;
        end_of_test;
    end

    initial begin
        repeat (6) tick;
        srst = 1'b0;
        test_boot;
        test_aon;
        test_load;
        test_store_crc(16'h1000, ncc_pkg::NCC_OP_STORE);
        test_store_crc(16'h4000, ncc_pkg::NCC_OP_CRC);
        test_resets;
        test_step;
        end_of_test;
    end
endmodule
